// >>> testbench/splr_rx_sva.sv
// checker for splr_rx: colour mapping, word hold and word latency
// assumes the port names of splr_rx; bound below the module
`default_nettype none
module splr_rx_sva #(
    parameter OUT_W = 28
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link and straps
    input wire logic link_period_start,
    input wire logic msb_on_lane3,
    input wire logic three_lane_mode,
    // pixel side
    input wire logic pixel_valid,
    input wire logic pixel_ready,
    input wire logic [OUT_W-1:0] parallel_pixel_out,
    input wire logic [7:0] red,
    input wire logic [7:0] green,
    input wire logic [7:0] blue,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic active_pixel_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [OUT_W-1:0] w = parallel_pixel_out;
    wire logic v4 = pixel_valid && !three_lane_mode;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // a word already in flight shows by the third cycle, so wait it out
    sequence s_idle_mark;
        link_period_start && !pixel_valid ##2 !pixel_valid;
    endsequence
    a_word_latency: assert property (s_idle_mark |-> ##14 pixel_valid)
        else $error("word not presented in time");
    a_hold_stall: assert property (pixel_valid && !pixel_ready |=>
        pixel_valid && $stable(w)) else $error("word changed in stall");
    a_sync_bits_pos: assert property (v4 |->
        {active_pixel_flag, vsync, hsync} == w[26:24]) else $error("sync");
    a_red_msb_map: assert property (v4 && msb_on_lane3 |->
        red == {w[5], w[27], w[6], w[4:0]}) else $error("red msb map");
    a_green_msb_map: assert property (v4 && msb_on_lane3 |->
        green == {w[11:10], w[14:12], w[9:7]}) else $error("green map");
    a_blue_msb_map: assert property (v4 && msb_on_lane3 |->
        blue == {w[17:16], w[22:18], w[15]}) else $error("blue map");
    a_red_lsb_map: assert property (v4 && !msb_on_lane3 |->
        red == {w[6], w[4:0], w[5], w[27]}) else $error("red lsb map");
    a_three_lane_drop: assert property (
        pixel_valid && three_lane_mode |->
        {red[1:0], green[1:0], blue[1:0]} == 6'h0) else $error("low bits");
endmodule // splr_rx_sva
bind splr_rx splr_rx_sva #(.OUT_W(OUT_W)) splr_rx_sva_inst (.*);
`default_nettype wire

// >>> testbench/splr_tx_model.sv
// link transmitter model: serialises 28-bit words onto four lanes
// assumes en and word change on the rising edge only
`default_nettype none
module splr_tx_model (
    // clock
    input wire logic core_clk,
    // word source
    input wire logic en,
    input wire logic lane3_open,
    input wire logic [27:0] word,
    // link
    output logic [3:0] lane,
    output logic mark
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic [27:0] cur = 28'h000_0000;
    logic run = 1'b0;
    // output position carried by each lane slot, lane 0 first
    int lmap [28] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 12, 13, 14, 15, 18,
        19, 20, 21, 22, 24, 25, 26, 27, 5, 10, 11, 16, 17, 23};
    initial lane = 4'h0;
    initial mark = 1'b0;
    // two cycles per bit, seven bits a period; idle lanes toggle
    always @(negedge core_clk) begin
        if (cnt == 4'h0) begin
            cur = word;
            run = en;
        end
        mark <= run && cnt == 4'h0;
        for (int i = 0; i < 3; i++) begin
            lane[i] <= run ? cur[lmap[i*7 + cnt/2]] : ~lane[i];
        end
        lane[3] <= run && !lane3_open ? cur[lmap[21 + cnt/2]] :
            ~lane[3];
        cnt <= (cnt == 4'hd || !run) ? 4'h0 : cnt + 4'h1;
    end
endmodule // splr_tx_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench: random words through model and receiver
// assumes splr_rx with its default fifo depth
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, en, open3, msb, three, ready, stall;
    logic pixel_valid, hsync, vsync, act, spare, overflow, mark;
    logic [3:0] lane;
    logic [27:0] tx_word, pout, exp;
    logic [7:0] red, green, blue;
    logic [31:0] seed = 32'h0000_5f98;
    logic [27:0] q[$];
    int miscompares = 0;
    int cmp_count = 0;
    int n = 0;
    int tbl [24] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8, 9, 12, 13, 14, 10, 11,
        15, 18, 19, 20, 21, 22, 16, 17};
    splr_tx_model splr_tx_model_inst (.core_clk(core_clk), .en(en),
        .lane3_open(open3), .word(tx_word), .lane(lane), .mark(mark));
    splr_rx splr_rx_inst (.core_clk(core_clk), .rst(rst),
        .lane0_serial_in(lane[0]), .lane1_serial_in(lane[1]),
        .lane2_serial_in(lane[2]), .lane3_serial_in(lane[3]),
        .link_period_start(mark), .msb_on_lane3(msb),
        .three_lane_mode(three), .pixel_valid(pixel_valid),
        .pixel_ready(ready), .parallel_pixel_out(pout), .red(red),
        .green(green), .blue(blue), .hsync(hsync), .vsync(vsync),
        .active_pixel_flag(act), .spare_bit(spare), .overflow(overflow));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] col(logic [27:0] w, int c);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = w[tbl[c*8 + i]];
        if (!msb) r = {r[5:0], r[7:6]};
        if (three) r[1:0] = 2'h0;
        return r;
    endfunction
    task automatic chk(input logic [27:0] got, input logic [27:0] want);
        cmp_count++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // straps change only while the link is idle and drained
    task automatic run_mode(input logic m, input logic t, input int words,
        input int left);
        @(negedge core_clk);
        msb = m;
        three = t;
        @(posedge core_clk);
        open3 <= t;
        en <= 1'b1;
        repeat (words * 14) @(posedge core_clk);
        en <= 1'b0;
        for (int i = 0; i < 400 && q.size() > 0; i++) @(negedge core_clk);
        chk(28'(q.size()), 28'(left));
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // three corner words in every sixteen, the rest random ones
    always @(posedge core_clk) begin
        if (mark === 1'b1) begin
            q.push_back(tx_word);
            n++;
            tx_word <= n % 16 < 3 ? {14{n[1:0]}} : rnd();
        end
        if (!rst && pixel_valid === 1'b1 && ready === 1'b1) begin
            exp = q.pop_front();
            // in three-lane use every lane3 position reads zero
            chk(pout, exp & (three ? 28'h77c_f3df : 28'hfff_ffff));
            chk({24'h0, hsync, vsync, act, spare}, {24'h0, exp[24], exp[25],
                exp[26], exp[23] & !three});
            chk({4'h0, red, green, blue},
                {4'h0, col(exp, 0), col(exp, 1), col(exp, 2)});
        end
    end
    always @(negedge core_clk) ready = !stall && rnd() % 4 != 0;
    initial begin
        rst = 1'b1; en = 1'b0; open3 = 1'b0; msb = 1'b1; three = 1'b0;
        stall = 1'b0; ready = 1'b0; tx_word = 28'hfff_ffff;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        run_mode(1'b1, 1'b0, 40, 0);
        run_mode(1'b0, 1'b0, 40, 0);
        run_mode(1'b0, 1'b1, 40, 0);
        chk({27'h0, overflow}, 28'h000_0000);
        stall = 1'b1;
        run_mode(1'b1, 1'b0, 12, 12);
        chk({27'h0, overflow}, 28'h000_0001);
        // eight in the fifo plus one in the output stage survive the stall
        stall = 1'b0;
        repeat (200) @(negedge core_clk);
        chk(28'(q.size()), 28'h000_0003);
        complete_run();
    end
    initial begin
        #2000000;
        miscompares++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire

// >>> verilog/splr_consts.vh
// constants for the serial pixel link receiver
// assumes inclusion by splr_rx.v only, not by splr_fifo.v
`ifndef SPLR_CONSTS_VH
`define SPLR_CONSTS_VH
`define SPLR_BITS_PER_LANE 7
`define SPLR_SLOT_LAST 3'h6
`define SPLR_SLOT_FIRST 3'h0
`define SPLR_LANES 4
`define SPLR_OUT_W 28
`define SPLR_OUT_W3 21
`define SPLR_FIFO_DEPTH 8
// output bit positions in the parallel word
`define SPLR_POS_HSYNC 24
`define SPLR_POS_VSYNC 25
`define SPLR_POS_ACTIVE 26
`define SPLR_POS_SPARE 23
// oversample phase that centres the strobe in a bit slot
`define SPLR_OVS 2
`define SPLR_OVS_MID 1'h1
`endif

// >>> verilog/splr_fifo.v
// parameterised word fifo, flip-flop storage, valid/ready both sides
// assumes one clock and an asynchronous active-high reset
`default_nettype none
module splr_fifo #(
    parameter WIDTH = 28,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            // pointers wrap only for power-of-two depths
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // splr_fifo
`default_nettype wire

// >>> verilog/splr_rx.v
// serial pixel link receiver: four lanes deserialised to 28-bit words
// assumes lanes and the link frame marker are sampled on core_clk,
// oversampled twice per bit, frame marker high on a period's first sample
// Summary of operation
// - every lane yields exactly seven bits each link clock period
// - sample bit n mid-slot, at (n + 0.5) times period over seven
// - slots numbered zero to six, each captured at its centre
// - msb mapping: lane3 holds colour msbs and spare; syncs at 24..26
// - in 18-bit use colour lsbs from lane3 are dropped
// - four-lane mode gives 28 outputs: 24 colour, 3 timing, spare
// - three-lane mode gives 21 outputs: 18 colour plus 3 timing
`default_nettype none
`include "splr_consts.vh"
module splr_rx #(
    parameter OUT_W = `SPLR_OUT_W,
    parameter DEPTH = `SPLR_FIFO_DEPTH
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // link: lanes and a period marker recovered from the forwarded clock
    input wire lane0_serial_in,
    input wire lane1_serial_in,
    input wire lane2_serial_in,
    input wire lane3_serial_in,
    input wire link_period_start,
    // mode straps
    input wire msb_on_lane3,
    input wire three_lane_mode,
    // pixel side
    output wire pixel_valid,
    input wire pixel_ready,
    output reg [OUT_W-1:0] parallel_pixel_out,
    output reg [7:0] red,
    output reg [7:0] green,
    output reg [7:0] blue,
    output reg hsync,
    output reg vsync,
    output reg active_pixel_flag,
    output reg spare_bit,
    output wire overflow
);
    reg [2:0] slot;
    reg phase;
    reg [6:0] shift0;
    reg [6:0] shift1;
    reg [6:0] shift2;
    reg [6:0] shift3;
    reg word_strobe;
    reg framed;
    reg [OUT_W-1:0] next_word;
    reg ovf;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [OUT_W-1:0] fifo_out;
    wire take;
    wire [3:0] lanes;
    assign lanes = {lane3_serial_in, lane2_serial_in,
                    lane1_serial_in, lane0_serial_in};
    assign overflow = ovf;

    // slot counter: advance on the mid phase of every slot, word strobe on the last
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slot <= `SPLR_SLOT_FIRST;
            phase <= 1'b0;
            word_strobe <= 1'b0;
            framed <= 1'b0;
        end else begin
            word_strobe <= 1'b0;
            if (link_period_start) begin
                slot <= `SPLR_SLOT_FIRST;
                phase <= 1'b1;
                framed <= 1'b1;
            end else begin
                phase <= ~phase;
                if (phase == `SPLR_OVS_MID) begin
                    if (slot == `SPLR_SLOT_LAST) begin
                        slot <= `SPLR_SLOT_FIRST;
                        // a period with no marker is noise on idle lanes,
                        // so it must never reach the pixel side
                        word_strobe <= framed; // all seven taken
                        framed <= 1'b0;
                    end else begin
                        slot <= slot + 3'h1;
                    end
                end
            end
        end
    end

    // capture each lane bit in its slot position
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift0 <= 7'h00;
            shift1 <= 7'h00;
            shift2 <= 7'h00;
            shift3 <= 7'h00;
        end else if (phase == `SPLR_OVS_MID && !link_period_start &&
                     framed) begin
            shift0[slot] <= lanes[0];
            shift1[slot] <= lanes[1];
            shift2[slot] <= lanes[2];
            // unconnected lane reads as zero in three-lane use
            shift3[slot] <= lanes[3] & ~three_lane_mode;
        end
    end

    // lane-to-output map, slots in order; syncs ride on lane2 so that
    // three-lane use keeps them, lane3 carries only colour extras and spare
    always @* begin
        next_word = {OUT_W{1'b0}};
        // lane0: outputs 0-4, 6, 7
        next_word[4:0] = shift0[4:0];
        next_word[6] = shift0[5];
        next_word[7] = shift0[6];
        // lane1: outputs 8, 9, 12-15, 18
        next_word[9:8] = shift1[1:0];
        next_word[15:12] = shift1[5:2];
        next_word[18] = shift1[6];
        // lane2: outputs 19-22, 24-26
        next_word[22:19] = shift2[3:0];
        next_word[26:24] = shift2[6:4];
        // lane3: outputs 27, 5, 10, 11, 16, 17, 23
        // shift3 already reads zero in three-lane use
        next_word[27] = shift3[0];
        next_word[5] = shift3[1];
        next_word[11:10] = shift3[3:2];
        next_word[17:16] = shift3[5:4];
        next_word[23] = shift3[6];
    end

    // buffer absorbs pixel-side stalls; link cannot wait, so flag loss
    splr_fifo #(
        .WIDTH(OUT_W),
        .DEPTH(DEPTH),
        .AW(3)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(word_strobe),
        .in_ready(fifo_in_ready),
        .in_data(next_word),
        .out_valid(fifo_out_valid),
        .out_ready(take),
        .out_data(fifo_out)
    );

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovf <= 1'b0;
        end else if (word_strobe && !fifo_in_ready) begin
            ovf <= 1'b1;
        end
    end

    // one-entry output stage, all fields loaded together
    reg out_full;
    assign pixel_valid = out_full;
    assign take = fifo_out_valid && (!out_full || pixel_ready);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_full <= 1'b0;
            parallel_pixel_out <= {OUT_W{1'b0}};
            red <= 8'h00;
            green <= 8'h00;
            blue <= 8'h00;
            hsync <= 1'b0;
            vsync <= 1'b0;
            active_pixel_flag <= 1'b0;
            spare_bit <= 1'b0;
        end else begin
            if (pixel_ready) begin
                out_full <= 1'b0;
            end
            if (take) begin
                out_full <= 1'b1;
                parallel_pixel_out <= fifo_out;
                hsync <= fifo_out[`SPLR_POS_HSYNC];
                vsync <= fifo_out[`SPLR_POS_VSYNC];
                active_pixel_flag <= fifo_out[`SPLR_POS_ACTIVE];
                spare_bit <= fifo_out[`SPLR_POS_SPARE] & ~three_lane_mode;
                if (msb_on_lane3 && !three_lane_mode) begin
                    // msbs on the fourth lane
                    red <= {fifo_out[5], fifo_out[27], fifo_out[6],
                            fifo_out[4:0]};
                    green <= {fifo_out[11], fifo_out[10],
                              fifo_out[14:12], fifo_out[9:7]};
                    blue <= {fifo_out[17], fifo_out[16],
                             fifo_out[22:18], fifo_out[15]};
                end else if (three_lane_mode) begin
                    // msbs from lanes 0..2; lane3 lsbs dropped
                    red <= {fifo_out[6], fifo_out[4:0], 2'b00};
                    green <= {fifo_out[14:12], fifo_out[9:7], 2'b00};
                    blue <= {fifo_out[22:18], fifo_out[15], 2'b00};
                end else begin
                    // lsb mapping: lane3 carries the two low bits
                    red <= {fifo_out[6], fifo_out[4:0], fifo_out[5],
                            fifo_out[27]};
                    green <= {fifo_out[14:12], fifo_out[9:7],
                              fifo_out[11], fifo_out[10]};
                    blue <= {fifo_out[22:18], fifo_out[15],
                             fifo_out[17], fifo_out[16]};
                end
            end
        end
    end
endmodule // splr_rx
`default_nettype wire
